/* pkg/rorng_pkg.sv */
// Purpose: Shared constants and carriers of the ring-oscillator RNG block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Register indices times four give the byte addresses
`default_nettype none
package rorng_pkg;
   // Bus geometry
   localparam int RORNG_ADDR_W = 18;
   localparam int RORNG_IDX_W = 16;
   localparam int RORNG_DATA_W = 32;
   localparam int RORNG_IDX_LSB = 2;
   // Register indices; byte address is four times the index
   localparam logic [15:0] RORNG_IDX_CTRL = 16'h4000;
   localparam logic [15:0] RORNG_IDX_IRQ_SRC = 16'h4002;
   localparam logic [15:0] RORNG_IDX_IRQ_GLB = 16'h4003;
   localparam logic [15:0] RORNG_IDX_MODE = 16'h4004;
   localparam logic [15:0] RORNG_IDX_FLAGS = 16'h4008;
   localparam logic [15:0] RORNG_IDX_REV = 16'h4010;
   localparam logic [15:0] RORNG_IDX_PROJ_LO = 16'h4012;
   localparam logic [15:0] RORNG_IDX_PROJ_HI = 16'h4013;
   localparam logic [15:0] RORNG_IDX_PP_THR = 16'h4020;
   localparam logic [15:0] RORNG_IDX_RAW_THR = 16'h4022;
   localparam logic [15:0] RORNG_IDX_PP_LVL = 16'h4024;
   localparam logic [15:0] RORNG_IDX_RAW_LVL = 16'h4028;
   localparam logic [15:0] RORNG_IDX_DATA = 16'h4030;
   // Field positions
   localparam int RORNG_CTRL_EN_BIT = 0;
   localparam int RORNG_CTRL_MASK_LSB = 1;
   localparam int RORNG_MASK_W = 4;
   localparam int RORNG_DATA_IE_BIT = 1;
   localparam int RORNG_EMPTY_IE_BIT = 2;
   localparam int RORNG_GLOBAL_IE_BIT = 0;
   localparam int RORNG_MODE_BIT = 0;
   localparam int RORNG_FLAG_READY_BIT = 1;
   localparam int RORNG_FLAG_EMPTY_BIT = 2;
   localparam int RORNG_THR_W = 3;
   localparam int RORNG_LVL_W = 8;
   // Reset values
   localparam logic [7:0] RORNG_CTRL_RST = 8'h1F;
   localparam logic [7:0] RORNG_IRQ_SRC_RST = 8'h02;
   localparam logic [7:0] RORNG_IRQ_GLB_RST = 8'h01;
   localparam logic [7:0] RORNG_MODE_RST = 8'h00;
   localparam logic [7:0] RORNG_THR_RST = 8'h07;
   // Bus answers
   localparam logic [1:0] RORNG_RESP_OKAY = 2'h0;
   localparam logic [1:0] RORNG_RESP_SLVERR = 2'h2;
   // Master to slave signals of the register bus
   typedef struct packed {
      logic awvalid;
      logic [RORNG_ADDR_W-1:0] awaddr;
      logic [2:0] awprot;
      logic wvalid;
      logic [RORNG_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [RORNG_ADDR_W-1:0] araddr;
      logic [2:0] arprot;
      logic rready;
   } rorng_axi_req_type;
   // Slave to master signals of the register bus
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [RORNG_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } rorng_axi_rsp_type;
   // One entropy word offered by the sources
   typedef struct packed {
      logic valid;
      logic [RORNG_DATA_W-1:0] data;
   } rorng_word_type;
endpackage : rorng_pkg
`default_nettype wire

/* hdl/rorng_top.sv */
// Purpose: Control, status and buffering of a ring-oscillator RNG
// Assumes: Entropy words arrive on ref_clk from on-chip sources
// Notes: Two word FIFOs, raw and mixed; one read port pops the selected one
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Word FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module rorng_fifo import rorng_pkg::*; #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32,
   parameter int LEVEL_W = 8
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [LEVEL_W-1:0] level
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [LEVEL_W-1:0] FULL_LVL = LEVEL_W'(DEPTH);
   // Whole FIFO state; depth must be a power of two
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [LEVEL_W-1:0] count;
   } rorng_fifo_state_type;
   rorng_fifo_state_type state; // Registered state
   rorng_fifo_state_type next_state; // Value for next edge
   logic push; // Word accepted this cycle
   logic pop; // Word removed this cycle

   // Honest flags come straight from the count
   assign in_ready = (state.count != FULL_LVL);
   assign out_valid = (state.count != '0);
   assign out_data = state.mem[state.rd_ptr];
   assign level = state.count;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next state of pointers, storage and count
   always_comb begin
      next_state = state;
      if (push) begin
         next_state.mem[state.wr_ptr] = in_data;
         next_state.wr_ptr = state.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_state.rd_ptr = state.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_state.count = state.count + 1'b1;
      end else if (pop && !push) begin
         next_state.count = state.count - 1'b1;
      end
   end

   // Register the state
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule : rorng_fifo

// ----------------------------------------------------------------
// Register file, flags and data path
// ----------------------------------------------------------------
// Functional notes
// R01: Generator enable bit, reset set
// R02: Four source enables, all reset on
// R03: Data interrupt enable, reset enabled
// R04: Empty-read interrupt enable, reset disabled
// R05: Global enable gates individual interrupt enables
// R06: Mode bit: raw or post-processed output
// R07: Post-processed threshold crossing sets data ready
// R08: Raw threshold crossing sets data ready
// R09: Post-processed FIFO count readable, reset zero
// R10: Configuration frozen while generator enabled; the mode bit stays writable while running
// R11: Data ready cleared by one, edge set
// R12: Empty data read sets error flag
// R13: Flags not cleared while generator disabled
// R14: Reserved bits read zero, writes ignored
// R15: Enabled flags drive one level interrupt
module rorng_top import rorng_pkg::*; #(
   parameter int FIFO_DEPTH = 32,
   parameter logic [3:0] MINOR_REV = 4'h1, // Arbitrary value
   parameter logic [3:0] MAJOR_REV = 4'h1, // Arbitrary value
   parameter logic [7:0] PROJECT_LO = 8'h5A, // Arbitrary value
   parameter logic [7:0] PROJECT_HI = 8'hA5 // Arbitrary value
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire rorng_axi_req_type axi_req,
   output rorng_axi_rsp_type axi_rsp,
   input wire rorng_word_type entropy_in,
   output logic entropy_ready,
   output logic [RORNG_MASK_W-1:0] source_enable,
   output logic irq
);
   // All block state in one record
   typedef struct packed {
      logic gen_en; // Generator running
      logic [RORNG_MASK_W-1:0] src_mask; // Per-source enables
      logic data_ie; // Data ready interrupt enable
      logic empty_ie; // Empty read interrupt enable
      logic global_ie; // Global interrupt gate
      logic pp_sel; // Post-processed path selected
      logic data_ready; // Sticky data ready flag
      logic empty_err; // Sticky empty read flag
      logic [RORNG_THR_W-1:0] pp_thr; // Mixed FIFO threshold
      logic [RORNG_THR_W-1:0] raw_thr; // Raw FIFO threshold
      logic [RORNG_LVL_W-1:0] pp_prev; // Mixed level last cycle
      logic [RORNG_LVL_W-1:0] raw_prev; // Raw level last cycle
      logic [RORNG_DATA_W-1:0] mix; // Last mixed word
      logic aw_held; // Write address captured
      logic [RORNG_IDX_W-1:0] aw_idx; // Captured write index
      logic w_held; // Write data captured
      logic [7:0] wbyte; // Captured low data byte
      logic wlane; // Low byte lane was strobed
      logic bvalid; // Write answer pending
      logic [1:0] bresp; // Write answer code
      logic rvalid; // Read answer pending
      logic [RORNG_DATA_W-1:0] rdata; // Read answer data
      logic [1:0] rresp; // Read answer code
      logic irq; // Interrupt level
   } rorng_state_type;
   rorng_state_type state; // Registered state
   rorng_state_type next_state; // Value for next edge

   logic raw_in_valid; // Offer to raw FIFO
   logic raw_in_ready; // Raw FIFO has room
   logic raw_out_valid; // Raw FIFO holds a word
   logic raw_pop; // Raw word taken by a read
   logic [RORNG_DATA_W-1:0] raw_out; // Head of raw FIFO
   logic [RORNG_LVL_W-1:0] raw_lvl; // Raw FIFO level
   logic pp_in_valid; // Offer to mixed FIFO
   logic pp_in_ready; // Mixed FIFO has room
   logic pp_out_valid; // Mixed FIFO holds a word
   logic pp_pop; // Mixed word taken by a read
   logic [RORNG_DATA_W-1:0] pp_out; // Head of mixed FIFO
   logic [RORNG_DATA_W-1:0] pp_word; // Word entering mixed FIFO
   logic [RORNG_LVL_W-1:0] pp_lvl; // Mixed FIFO level
   logic aw_take; // Write address handshake
   logic w_take; // Write data handshake
   logic ar_take; // Read address handshake
   logic [RORNG_IDX_W-1:0] ar_idx; // Read index
   logic data_read; // Read of the data register
   logic sel_valid; // Selected FIFO holds a word

   // ----------------------------------------------------------------
   // Entropy routing
   // ----------------------------------------------------------------
   // Words enter only while running; the mode picks the FIFO
   assign raw_in_valid = entropy_in.valid && state.gen_en && !state.pp_sel; // R06
   assign pp_in_valid = entropy_in.valid && state.gen_en && state.pp_sel; // R06
   // Back-pressure from the chosen FIFO stalls the sources
   assign entropy_ready = state.gen_en && (state.pp_sel ? pp_in_ready : raw_in_ready);
   // Simple running mix; stands in for a real conditioner
   assign pp_word = entropy_in.data ^ {state.mix[RORNG_DATA_W-2:0], state.mix[RORNG_DATA_W-1]};
   // Sources run only with the generator on
   assign source_enable = state.gen_en ? state.src_mask : '0; // R01 R02
   assign irq = state.irq;

   // ----------------------------------------------------------------
   // Bus handshakes
   // ----------------------------------------------------------------
   // One write and one read outstanding; ready drops while answering
   always_comb begin
      axi_rsp.awready = !state.aw_held && !state.bvalid;
      axi_rsp.wready = !state.w_held && !state.bvalid;
      axi_rsp.bvalid = state.bvalid;
      axi_rsp.bresp = state.bresp;
      axi_rsp.arready = !state.rvalid;
      axi_rsp.rvalid = state.rvalid;
      axi_rsp.rdata = state.rdata;
      axi_rsp.rresp = state.rresp;
   end
   assign aw_take = axi_req.awvalid && axi_rsp.awready;
   assign w_take = axi_req.wvalid && axi_rsp.wready;
   assign ar_take = axi_req.arvalid && axi_rsp.arready;
   assign ar_idx = axi_req.araddr[RORNG_ADDR_W-1:RORNG_IDX_LSB];
   assign data_read = ar_take && (ar_idx == RORNG_IDX_DATA);
   assign sel_valid = state.pp_sel ? pp_out_valid : raw_out_valid;
   // A read pops only the FIFO the mode selects
   assign raw_pop = data_read && !state.pp_sel && raw_out_valid;
   assign pp_pop = data_read && state.pp_sel && pp_out_valid;

   // ----------------------------------------------------------------
   // Buffers
   // ----------------------------------------------------------------
   rorng_fifo #(
      .WIDTH(RORNG_DATA_W),
      .DEPTH(FIFO_DEPTH),
      .LEVEL_W(RORNG_LVL_W)
   ) u_raw_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(raw_in_valid),
      .in_ready(raw_in_ready),
      .in_data(entropy_in.data),
      .out_valid(raw_out_valid),
      .out_ready(raw_pop),
      .out_data(raw_out),
      .level(raw_lvl)
   );

   rorng_fifo #(
      .WIDTH(RORNG_DATA_W),
      .DEPTH(FIFO_DEPTH),
      .LEVEL_W(RORNG_LVL_W)
   ) u_pp_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(pp_in_valid),
      .in_ready(pp_in_ready),
      .in_data(pp_word),
      .out_valid(pp_out_valid),
      .out_ready(pp_pop),
      .out_data(pp_out),
      .level(pp_lvl)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Flags first, then the bus write, then the read answer
   always_comb begin
      logic aw_have;
      logic w_have;
      logic do_write;
      logic clr_ready;
      logic clr_empty;
      logic set_ready;
      logic set_empty;
      logic [7:0] wb;
      logic [RORNG_LVL_W-1:0] pp_thr_w;
      logic [RORNG_LVL_W-1:0] raw_thr_w;
      aw_have = 1'b0;
      w_have = 1'b0;
      do_write = 1'b0;
      clr_ready = 1'b0;
      clr_empty = 1'b0;
      set_ready = 1'b0;
      set_empty = 1'b0;
      wb = 8'h00;
      pp_thr_w = RORNG_LVL_W'(state.pp_thr);
      raw_thr_w = RORNG_LVL_W'(state.raw_thr);
      next_state = state;

      // Mixer remembers each word it passed on
      if (pp_in_valid && pp_in_ready) begin
         next_state.mix = pp_word;
      end
      // Levels are tracked to see a rising crossing
      next_state.pp_prev = pp_lvl;
      next_state.raw_prev = raw_lvl;

      // Only a step from threshold minus one sets the flag
      if (pp_lvl == pp_thr_w && state.pp_prev == pp_thr_w - 1'b1) begin
         set_ready = 1'b1; // R07 R11
      end
      if (raw_lvl == raw_thr_w && state.raw_prev == raw_thr_w - 1'b1) begin
         set_ready = 1'b1; // R08 R11
      end
      // Reading an empty data register is flagged every time
      if (data_read && !sel_valid) begin
         set_empty = 1'b1; // R12
      end

      // Capture write address and data in either order
      if (aw_take) begin
         next_state.aw_held = 1'b1;
         next_state.aw_idx = axi_req.awaddr[RORNG_ADDR_W-1:RORNG_IDX_LSB];
      end
      if (w_take) begin
         next_state.w_held = 1'b1;
         next_state.wbyte = axi_req.wdata[7:0];
         next_state.wlane = axi_req.wstrb[0];
      end
      aw_have = next_state.aw_held;
      w_have = next_state.w_held;
      do_write = aw_have && w_have && !state.bvalid;
      wb = next_state.wbyte;

      if (do_write) begin
         next_state.aw_held = 1'b0;
         next_state.w_held = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = RORNG_RESP_OKAY;
         // Only the low byte lane carries register bits
         if (!next_state.wlane) begin
            // Nothing stored without the low lane
         end else if (next_state.aw_idx == RORNG_IDX_CTRL) begin
            next_state.gen_en = wb[RORNG_CTRL_EN_BIT]; // R01
            // Source mask is frozen while running
            if (!state.gen_en) begin
               next_state.src_mask = wb[RORNG_CTRL_MASK_LSB +: RORNG_MASK_W]; // R02 R10
            end
         end else if (next_state.aw_idx == RORNG_IDX_IRQ_SRC) begin
            if (!state.gen_en) begin
               next_state.data_ie = wb[RORNG_DATA_IE_BIT]; // R03 R10
               next_state.empty_ie = wb[RORNG_EMPTY_IE_BIT]; // R04 R10
            end
         end else if (next_state.aw_idx == RORNG_IDX_IRQ_GLB) begin
            if (!state.gen_en) begin
               next_state.global_ie = wb[RORNG_GLOBAL_IE_BIT]; // R05 R10
            end
         end else if (next_state.aw_idx == RORNG_IDX_MODE) begin
            // Path switch stays allowed while running
            next_state.pp_sel = wb[RORNG_MODE_BIT]; // R06
         end else if (next_state.aw_idx == RORNG_IDX_FLAGS) begin
            // Clears are ignored while the generator is off
            if (state.gen_en) begin
               clr_ready = wb[RORNG_FLAG_READY_BIT]; // R11 R13
               clr_empty = wb[RORNG_FLAG_EMPTY_BIT]; // R12 R13
            end
         end else if (next_state.aw_idx == RORNG_IDX_PP_THR) begin
            if (!state.gen_en) begin
               next_state.pp_thr = wb[RORNG_THR_W-1:0]; // R07 R10
            end
         end else if (next_state.aw_idx == RORNG_IDX_RAW_THR) begin
            if (!state.gen_en) begin
               next_state.raw_thr = wb[RORNG_THR_W-1:0]; // R08 R10
            end
         end else if (next_state.aw_idx == RORNG_IDX_REV || next_state.aw_idx == RORNG_IDX_PROJ_LO
                      || next_state.aw_idx == RORNG_IDX_PROJ_HI || next_state.aw_idx == RORNG_IDX_PP_LVL
                      || next_state.aw_idx == RORNG_IDX_RAW_LVL || next_state.aw_idx == RORNG_IDX_DATA) begin
            // Read-only registers ignore writes
         end else begin
            next_state.bresp = RORNG_RESP_SLVERR;
         end
      end
      if (state.bvalid && axi_req.bready) begin
         next_state.bvalid = 1'b0;
      end

      // Set wins over a clear in the same cycle
      if (set_ready) begin
         next_state.data_ready = 1'b1;
      end else if (clr_ready) begin
         next_state.data_ready = 1'b0;
      end
      if (set_empty) begin
         next_state.empty_err = 1'b1;
      end else if (clr_empty) begin
         next_state.empty_err = 1'b0;
      end

      // Read answer; unused bits stay zero
      if (ar_take) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = RORNG_RESP_OKAY;
         next_state.rdata = '0; // R14
         if (ar_idx == RORNG_IDX_CTRL) begin
            next_state.rdata[RORNG_CTRL_EN_BIT] = state.gen_en;
            next_state.rdata[RORNG_CTRL_MASK_LSB +: RORNG_MASK_W] = state.src_mask;
         end else if (ar_idx == RORNG_IDX_IRQ_SRC) begin
            next_state.rdata[RORNG_DATA_IE_BIT] = state.data_ie;
            next_state.rdata[RORNG_EMPTY_IE_BIT] = state.empty_ie;
         end else if (ar_idx == RORNG_IDX_IRQ_GLB) begin
            next_state.rdata[RORNG_GLOBAL_IE_BIT] = state.global_ie;
         end else if (ar_idx == RORNG_IDX_MODE) begin
            next_state.rdata[RORNG_MODE_BIT] = state.pp_sel;
         end else if (ar_idx == RORNG_IDX_FLAGS) begin
            next_state.rdata[RORNG_FLAG_READY_BIT] = state.data_ready;
            next_state.rdata[RORNG_FLAG_EMPTY_BIT] = state.empty_err;
         end else if (ar_idx == RORNG_IDX_REV) begin
            next_state.rdata[7:0] = {MAJOR_REV, MINOR_REV};
         end else if (ar_idx == RORNG_IDX_PROJ_LO) begin
            next_state.rdata[7:0] = PROJECT_LO;
         end else if (ar_idx == RORNG_IDX_PROJ_HI) begin
            next_state.rdata[7:0] = PROJECT_HI;
         end else if (ar_idx == RORNG_IDX_PP_THR) begin
            next_state.rdata[RORNG_THR_W-1:0] = state.pp_thr;
         end else if (ar_idx == RORNG_IDX_RAW_THR) begin
            next_state.rdata[RORNG_THR_W-1:0] = state.raw_thr;
         end else if (ar_idx == RORNG_IDX_PP_LVL) begin
            next_state.rdata[RORNG_LVL_W-1:0] = pp_lvl; // R09
         end else if (ar_idx == RORNG_IDX_RAW_LVL) begin
            next_state.rdata[RORNG_LVL_W-1:0] = raw_lvl;
         end else if (ar_idx == RORNG_IDX_DATA) begin
            // Empty read answers zero with OKAY; the flag tells software
            if (sel_valid) begin
               next_state.rdata = state.pp_sel ? pp_out : raw_out;
            end
         end else begin
            next_state.rresp = RORNG_RESP_SLVERR;
         end
      end else if (state.rvalid && axi_req.rready) begin
         next_state.rvalid = 1'b0;
      end

      // Enabled flags through the global gate make one level
      next_state.irq = next_state.global_ie && // R05 R15
         ((next_state.data_ready && next_state.data_ie) || // R03
          (next_state.empty_err && next_state.empty_ie)); // R04
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset loads the documented defaults
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= '0;
         state.gen_en <= RORNG_CTRL_RST[RORNG_CTRL_EN_BIT]; // R01
         state.src_mask <= RORNG_CTRL_RST[RORNG_CTRL_MASK_LSB +: RORNG_MASK_W]; // R02
         state.data_ie <= RORNG_IRQ_SRC_RST[RORNG_DATA_IE_BIT]; // R03
         state.empty_ie <= RORNG_IRQ_SRC_RST[RORNG_EMPTY_IE_BIT]; // R04
         state.global_ie <= RORNG_IRQ_GLB_RST[RORNG_GLOBAL_IE_BIT]; // R05
         state.pp_sel <= RORNG_MODE_RST[RORNG_MODE_BIT]; // R06
         state.pp_thr <= RORNG_THR_RST[RORNG_THR_W-1:0]; // R07
         state.raw_thr <= RORNG_THR_RST[RORNG_THR_W-1:0]; // R08
      end else begin
         state <= next_state;
      end
   end
endmodule : rorng_top
`default_nettype wire

/* tb/rorng_chk.sv */
// Purpose: Port assertions for the RNG control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound from tb_top; sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module rorng_chk import rorng_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire rorng_axi_req_type axi_req,
   input wire rorng_axi_rsp_type axi_rsp,
   input wire rorng_word_type entropy_in,
   input wire logic entropy_ready,
   input wire logic [RORNG_MASK_W-1:0] source_enable,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Recent causes; flags and irq lag their cause by up to two edges
   logic [2:0] any_hist;
   logic [2:0] wr_hist;
   wire logic aw_take = axi_req.awvalid && axi_rsp.awready;
   wire logic ar_take = axi_req.arvalid && axi_rsp.arready;
   wire logic ent_take = entropy_in.valid && entropy_ready;
   // History shift registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         any_hist <= 3'h0;
         wr_hist <= 3'h0;
      end else begin
         any_hist <= {any_hist[1:0], aw_take || ar_take || ent_take};
         wr_hist <= {wr_hist[1:0], aw_take};
      end
   end
   irq_rise_cause_a: assert property ($rose(irq) |-> any_hist != 3'h0)
      else $error("irq rose with no fill, read or write");
   irq_fall_cause_a: assert property ($fell(irq) |-> wr_hist != 3'h0)
      else $error("irq fell without a register write");
   srcen_write_only_a: assert property ($changed(source_enable) |-> wr_hist != 3'h0)
      else $error("source enables moved without a write");
   write_answer_a: assert property (aw_take && axi_req.wvalid && axi_rsp.wready
      |=> axi_rsp.bvalid) else $error("write response late");
   read_answer_a: assert property (ar_take |=> axi_rsp.rvalid)
      else $error("read data late");
   bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
   busy_refuse_a: assert property ((axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      and (axi_rsp.rvalid |-> !axi_rsp.arready)) else $error("request taken while busy");
endmodule : rorng_chk
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Register-level self-checking bench of the RNG block
// Assumes: AXI4-Lite master in the bench, entropy words fed directly
// Notes: Expected values come from the register map and reset table
`timescale 1ns/1ps
`default_nettype none
module tb_top import rorng_pkg::*;;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   rorng_axi_req_type axi_req = '0;
   rorng_axi_rsp_type axi_rsp;
   rorng_word_type entropy_in = '0;
   logic entropy_ready;
   logic [RORNG_MASK_W-1:0] source_enable;
   logic irq;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   always #50 ref_clk = ~ref_clk;
   rorng_top u_rorng_top (.ref_clk(ref_clk), .nrst(nrst), .axi_req(axi_req),
      .axi_rsp(axi_rsp), .entropy_in(entropy_in), .entropy_ready(entropy_ready),
      .source_enable(source_enable), .irq(irq));
   // Comparison with report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk
   // Write; address and data offered together, each released when taken
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge ref_clk);
      axi_req.awaddr <= {idx, 2'b00};
      axi_req.wdata <= {24'h0, d};
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (!axi_rsp.bvalid);
      axi_req.bready <= 1'b1;
      @(posedge ref_clk);
      axi_req.bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, axi_rsp.bresp});
   endtask : wr
   // Read and compare data and response
   task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge ref_clk);
      axi_req.araddr <= {idx, 2'b00};
      axi_req.arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (!axi_rsp.rvalid);
      axi_req.rready <= 1'b1;
      @(posedge ref_clk);
      axi_req.rready <= 1'b0;
      chk("rdata", {24'h0, d}, axi_rsp.rdata);
      chk("rresp", {30'h0, er}, {30'h0, axi_rsp.rresp});
   endtask : rd
   // Offer n words back to back, counting up
   task automatic push(input int n);
      @(posedge ref_clk);
      entropy_in.valid <= 1'b1;
      repeat (n) begin
         do @(posedge ref_clk); while (!entropy_ready);
         entropy_in.data <= entropy_in.data + 32'h1;
      end
      entropy_in.valid <= 1'b0;
   endtask : push
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         results();
      end
   end
   // Main sequence
   initial begin
      static logic [15:0] ri [8] = '{RORNG_IDX_CTRL, RORNG_IDX_IRQ_SRC, RORNG_IDX_IRQ_GLB,
         RORNG_IDX_MODE, RORNG_IDX_FLAGS, RORNG_IDX_PP_THR, RORNG_IDX_RAW_THR, RORNG_IDX_PP_LVL};
      static logic [7:0] rv [8] = '{8'h1F, 8'h02, 8'h01, 8'h00, 8'h00, 8'h07, 8'h07, 8'h00};
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) rd(ri[i], rv[i], RORNG_RESP_OKAY);
      chk("srcen", 32'hF, {28'h0, source_enable});
      wr(RORNG_IDX_RAW_THR, 8'h03, RORNG_RESP_OKAY);
      rd(RORNG_IDX_RAW_THR, 8'h07, RORNG_RESP_OKAY);
      rd(16'h4001, 8'h00, RORNG_RESP_SLVERR);
      wr(16'h4001, 8'hFF, RORNG_RESP_SLVERR);
      wr(RORNG_IDX_CTRL, 8'hFE, RORNG_RESP_OKAY);
      rd(RORNG_IDX_CTRL, 8'h1E, RORNG_RESP_OKAY);
      chk("srcen_off", 32'h0, {28'h0, source_enable});
      chk("ent_off", 32'h0, {31'h0, entropy_ready});
      wr(RORNG_IDX_RAW_THR, 8'hFB, RORNG_RESP_OKAY);
      rd(RORNG_IDX_RAW_THR, 8'h03, RORNG_RESP_OKAY);
      wr(RORNG_IDX_IRQ_SRC, 8'h06, RORNG_RESP_OKAY);
      wr(RORNG_IDX_PP_THR, 8'h02, RORNG_RESP_OKAY);
      wr(RORNG_IDX_CTRL, 8'h1F, RORNG_RESP_OKAY);
      push(3);
      rd(RORNG_IDX_FLAGS, 8'h02, RORNG_RESP_OKAY);
      chk("irq_data", 32'h1, {31'h0, irq});
      wr(RORNG_IDX_FLAGS, 8'h02, RORNG_RESP_OKAY);
      rd(RORNG_IDX_FLAGS, 8'h00, RORNG_RESP_OKAY);
      chk("irq_clear", 32'h0, {31'h0, irq});
      push(1);
      rd(RORNG_IDX_FLAGS, 8'h00, RORNG_RESP_OKAY);
      for (int i = 0; i < 4; i++) rd(RORNG_IDX_DATA, i[7:0], RORNG_RESP_OKAY);
      rd(RORNG_IDX_DATA, 8'h00, RORNG_RESP_OKAY);
      rd(RORNG_IDX_FLAGS, 8'h04, RORNG_RESP_OKAY);
      chk("irq_empty", 32'h1, {31'h0, irq});
      wr(RORNG_IDX_MODE, 8'h01, RORNG_RESP_OKAY);
      push(2);
      rd(RORNG_IDX_PP_LVL, 8'h02, RORNG_RESP_OKAY);
      rd(RORNG_IDX_FLAGS, 8'h06, RORNG_RESP_OKAY);
      wr(RORNG_IDX_CTRL, 8'h1E, RORNG_RESP_OKAY);
      wr(RORNG_IDX_FLAGS, 8'h06, RORNG_RESP_OKAY);
      rd(RORNG_IDX_FLAGS, 8'h06, RORNG_RESP_OKAY);
      wr(RORNG_IDX_IRQ_GLB, 8'h00, RORNG_RESP_OKAY);
      rd(RORNG_IDX_IRQ_GLB, 8'h00, RORNG_RESP_OKAY);
      chk("irq_gated", 32'h0, {31'h0, irq});
      results();
   end
endmodule : tb_top
bind rorng_top rorng_chk u_rorng_chk (.ref_clk(ref_clk), .nrst(nrst), .axi_req(axi_req),
   .axi_rsp(axi_rsp), .entropy_in(entropy_in), .entropy_ready(entropy_ready),
   .source_enable(source_enable), .irq(irq));
`default_nettype wire
